/* File: pkg/sste_regs.svh */
// Register indices, flag positions, reset values, opcodes and cycle counts of the execute block
`ifndef SSTE_REGS_SVH
`define SSTE_REGS_SVH

// Register indices; byte address is four times the index
`define SSTE_IDX_BASE_A     8'hD6
`define SSTE_IDX_BASE_B     8'hD7
`define SSTE_IDX_FLAGS      8'hE0
`define SSTE_IDX_STATUS     8'hE1

// Flag register bit positions
`define SSTE_FLAG_C         7
`define SSTE_FLAG_Z         6
`define SSTE_FLAG_S         5
`define SSTE_FLAG_V         4
`define SSTE_FLAG_D         3
`define SSTE_FLAG_H         2

// Status register bit positions
`define SSTE_STAT_STOPPED   0
`define SSTE_STAT_BUSY      1
`define SSTE_STAT_BADOP     2

// Reset values
`define SSTE_RST_BASE_A     8'h00
`define SSTE_RST_BASE_B     8'h00
`define SSTE_RST_FLAGS      8'h00

// Opcodes
`define SSTE_OP_SRA_R       8'hD0
`define SSTE_OP_SRA_IR      8'hD1
`define SSTE_OP_SRP         8'h31
`define SSTE_OP_STOP        8'h7F
`define SSTE_OP_SUB_BASE    8'h22
`define SSTE_OP_TCM_BASE    8'h62
`define SSTE_OP_SWAP_R      8'hF0
`define SSTE_OP_SWAP_IR     8'hF1

// Cycle counts
`define SSTE_CYC_SHORT      3'h4
`define SSTE_CYC_LONG       3'h6

`endif

/* File: pkg/sste_pkg.sv */
// Types shared by the shift, subtract and test execute block
package sste_pkg;

   typedef enum logic [2:0]
   {
      K_SRA,
      K_SRP,
      K_STOP,
      K_SUB,
      K_SWAP,
      K_TCM,
      K_BAD
   } sste_kind_t;

   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_EXEC,
      ST_STOP
   } sste_state_t;

endpackage : sste_pkg

/* File: design/sste_execute.sv */
// Execute datapath for shift, pointer load, stop, subtract, swap and masked test
//
// Summary of operation
// RQ1 - Arithmetic shift right keeps and copies bit 7
// RQ2 - Shift flags: C old bit0, V cleared
// RQ3 - Shift opcodes D0/D1, two bytes, four cycles
// RQ4 - Pointer load writes bits 3-7 of one base
// RQ5 - Pattern 00 loads both, forces bit3 0/1
// RQ6 - Pointer load opcode 31, four cycles, no flags
// RQ7 - Window bases sit at D6 and D7
// RQ8 - Stop halts CPU and system clocks, no flags
// RQ9 - Stop state retains all registers
// RQ10 - Stop exits only on reset or interrupt
// RQ11 - Waking by reset needs reset held long
// RQ12 - Subtract writes dst minus src, src untouched
// RQ13 - Subtract C borrow, Z zero, S sign
// RQ14 - Subtract overflow on opposite signs rule
// RQ15 - Subtract sets D, H means nibble borrow
// RQ16 - Subtract opcodes 22-26 with cycle counts
// RQ17 - Swap exchanges nibbles, Z and S updated
// RQ18 - Swap opcodes F0/F1, four cycles
// RQ19 - Masked test uses NOT dst AND src only
// RQ20 - Masked test Z, S set, V cleared
// RQ21 - Carry bit takes shifted bit or borrow
// RQ22 - Masked test uses subtract encodings, base 62
`timescale 1ns/1ps
`include "sste_regs.svh"

module sste_execute
   import sste_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   // Decoder issue
   input  wire logic        issue,
   input  wire logic [7:0]  opcode,
   input  wire logic [7:0]  dst_val,
   input  wire logic [7:0]  src_val,
   output logic             issue_ready,
   // Write-back
   output logic             done,
   output logic             wb_en,
   output logic [7:0]       wb_data,
   output logic [7:0]       flags,
   output logic [7:0]       base_a,
   output logic [7:0]       base_b,
   // Power-down
   input  wire logic        ext_int,
   output logic             cpu_clk_halt,
   output logic             sys_clk_halt,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   function automatic sste_kind_t decode_kind(input logic [7:0] op);
      sste_kind_t k;
      k = K_BAD;
      case (op)
         `SSTE_OP_SRA_R, `SSTE_OP_SRA_IR:   k = K_SRA;   // [RQ3]
         `SSTE_OP_SRP:                      k = K_SRP;   // [RQ6]
         `SSTE_OP_STOP:                     k = K_STOP;
         `SSTE_OP_SWAP_R, `SSTE_OP_SWAP_IR: k = K_SWAP;  // [RQ18]
         default:
         begin
            if (op >= `SSTE_OP_SUB_BASE && op <= `SSTE_OP_SUB_BASE + 8'h04)
               k = K_SUB;                                // [RQ16]
            else if (op >= `SSTE_OP_TCM_BASE && op <= `SSTE_OP_TCM_BASE + 8'h04)
               k = K_TCM;                                // [RQ22]
         end
      endcase
      return k;
   endfunction : decode_kind
   // Only the first two-byte form of subtract and test is short
   function automatic logic [2:0] op_cycles(input logic [7:0] op);
      logic [2:0] c;
      c = `SSTE_CYC_SHORT;
      if ((decode_kind(op) == K_SUB && op != `SSTE_OP_SUB_BASE) ||
          (decode_kind(op) == K_TCM && op != `SSTE_OP_TCM_BASE))
         c = `SSTE_CYC_LONG;                             // [RQ16] [RQ22]
      return c;
   endfunction : op_cycles
   function automatic logic [11:0] byte_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : byte_addr
   sste_state_t state_r;
   sste_state_t state_nxt;
   sste_kind_t  kind_r;
   logic [7:0]  opd_r;
   logic [7:0]  ops_r;
   logic [2:0]  cnt_r;
   logic        done_r;
   logic        wb_en_r;
   logic [7:0]  wb_data_r;
   logic [7:0]  flags_r;
   logic [7:0]  base_a_r;
   logic [7:0]  base_b_r;
   logic        badop_r;
   logic        issue_ready_r;
   logic        cpu_halt_r;
   logic        sys_halt_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        take;
   logic        finish;
   logic [7:0]  res;
   logic [8:0]  sub_sum;
   logic [4:0]  nib_sum;
   logic [7:0]  flags_nxt;
   logic        res_wr;
   logic        apb_acc;
   logic        apb_wr;
   logic        hit;
   logic [31:0] rd_val;
   assign take   = ce && issue && issue_ready_r;
   assign finish = (state_r == ST_EXEC) && (cnt_r == 3'h1);
   // State sequencing
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (issue && issue_ready_r)
               state_nxt = ST_EXEC;
         ST_EXEC:
            if (cnt_r == 3'h1)
               state_nxt = (kind_r == K_STOP) ? ST_STOP : ST_IDLE;    // [RQ8]
         ST_STOP:
            if (ext_int)
               state_nxt = ST_IDLE;                                  // [RQ10]
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // Reset is the other way out of stop; its length is the outside party's concern
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r       <= ST_IDLE;                                   // [RQ11]
         issue_ready_r <= 1'b0;
         cpu_halt_r    <= 1'b0;
         sys_halt_r    <= 1'b0;
      end
      else if (ce)
      begin
         state_r       <= state_nxt;
         issue_ready_r <= (state_nxt == ST_IDLE);
         cpu_halt_r    <= (state_nxt == ST_STOP);                    // [RQ8]
         sys_halt_r    <= (state_nxt == ST_STOP);                    // [RQ8]
      end
   end

   // Operand capture and cycle count
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         kind_r <= K_BAD;
         opd_r  <= 8'h00;
         ops_r  <= 8'h00;
         cnt_r  <= 3'h0;
      end
      else if (ce)
      begin
         if (take)
         begin
            kind_r <= decode_kind(opcode);
            opd_r  <= dst_val;
            ops_r  <= src_val;
            cnt_r  <= op_cycles(opcode);                             // [RQ3] [RQ6] [RQ16]
         end
         else if (state_r == ST_EXEC)
            cnt_r <= cnt_r - 3'h1;
      end
   end

   // Datapath and flag computation
   always_comb
   begin
      sub_sum   = {1'b0, opd_r} + {1'b0, ~ops_r} + 9'h001;           // [RQ12]
      nib_sum   = {1'b0, opd_r[3:0]} + {1'b0, ~ops_r[3:0]} + 5'h01;
      res       = 8'h00;
      res_wr    = 1'b0;
      flags_nxt = flags_r;
      case (kind_r)
         K_SRA:
         begin
            res    = {opd_r[7], opd_r[7:1]};                         // [RQ1]
            res_wr = 1'b1;
            flags_nxt[`SSTE_FLAG_C] = opd_r[0];                      // [RQ2] [RQ21]
            flags_nxt[`SSTE_FLAG_Z] = (res == 8'h00);                // [RQ2]
            flags_nxt[`SSTE_FLAG_S] = res[7];                        // [RQ2]
            flags_nxt[`SSTE_FLAG_V] = 1'b0;                          // [RQ2]
         end
         K_SUB:
         begin
            res    = sub_sum[7:0];                                   // [RQ12]
            res_wr = 1'b1;
            flags_nxt[`SSTE_FLAG_C] = ~sub_sum[8];                   // [RQ13] [RQ21]
            flags_nxt[`SSTE_FLAG_Z] = (res == 8'h00);                // [RQ13]
            flags_nxt[`SSTE_FLAG_S] = res[7];                        // [RQ13]
            flags_nxt[`SSTE_FLAG_V] = (opd_r[7] != ops_r[7]) && (res[7] == ops_r[7]); // [RQ14]
            flags_nxt[`SSTE_FLAG_D] = 1'b1;                          // [RQ15]
            flags_nxt[`SSTE_FLAG_H] = ~nib_sum[4];                   // [RQ15]
         end
         K_SWAP:
         begin
            // Undefined C and V are simply left as they were
            res    = {opd_r[3:0], opd_r[7:4]};                       // [RQ17]
            res_wr = 1'b1;
            flags_nxt[`SSTE_FLAG_Z] = (res == 8'h00);                // [RQ17]
            flags_nxt[`SSTE_FLAG_S] = res[7];                        // [RQ17]
         end
         K_TCM:
         begin
            res    = ~opd_r & ops_r;                                 // [RQ19]
            flags_nxt[`SSTE_FLAG_Z] = (res == 8'h00);                // [RQ20]
            flags_nxt[`SSTE_FLAG_S] = res[7];                        // [RQ20]
            flags_nxt[`SSTE_FLAG_V] = 1'b0;                          // [RQ20]
         end
         default:
            res_wr = 1'b0;
      endcase
   end
   // Result write-back, one done pulse per instruction
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         done_r    <= 1'b0;
         wb_en_r   <= 1'b0;
         wb_data_r <= 8'h00;
      end
      else if (ce)
      begin
         done_r  <= finish;
         wb_en_r <= finish && res_wr;                                // [RQ19]
         if (finish)
            wb_data_r <= res;
      end
   end
   // APB access decode
   assign apb_acc = psel && penable && pready_r;
   assign apb_wr  = apb_acc && pwrite && !pslverr_r && (state_r != ST_STOP); // [RQ9]
   assign hit     = (paddr == byte_addr(`SSTE_IDX_BASE_A)) || (paddr == byte_addr(`SSTE_IDX_BASE_B)) ||
                    (paddr == byte_addr(`SSTE_IDX_FLAGS))  || (paddr == byte_addr(`SSTE_IDX_STATUS));
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (paddr)
         byte_addr(`SSTE_IDX_BASE_A): rd_val = {24'h000000, base_a_r};   // [RQ7]
         byte_addr(`SSTE_IDX_BASE_B): rd_val = {24'h000000, base_b_r};   // [RQ7]
         byte_addr(`SSTE_IDX_FLAGS):  rd_val = {24'h000000, flags_r};
         byte_addr(`SSTE_IDX_STATUS): rd_val = {29'h0000000, badop_r, state_r == ST_EXEC, state_r == ST_STOP};
         default:                     rd_val = 32'h0000_0000;
      endcase
   end

   // Flags: instruction result wins over a software write in the same cycle
   always_ff @(posedge clk)
   begin
      if (srst)
         flags_r <= `SSTE_RST_FLAGS;
      else if (ce)
      begin
         if (finish)
            flags_r <= flags_nxt;                                    // [RQ6] [RQ8]
         else if (apb_wr && paddr == byte_addr(`SSTE_IDX_FLAGS))
            flags_r <= pwdata[7:0];
      end
   end

   // Window bases
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         base_a_r <= `SSTE_RST_BASE_A;
         base_b_r <= `SSTE_RST_BASE_B;
      end
      else if (ce)
      begin
         if (finish && kind_r == K_SRP)
         begin
            case (ops_r[1:0])
               2'b10: base_a_r[7:3] <= ops_r[7:3];                   // [RQ4]
               2'b01: base_b_r[7:3] <= ops_r[7:3];                   // [RQ4]
               2'b00:
               begin
                  base_a_r[7:3] <= {ops_r[7:4], 1'b0};               // [RQ5]
                  base_b_r[7:3] <= {ops_r[7:4], 1'b1};               // [RQ5]
               end
               default: base_a_r <= base_a_r;
            endcase
         end
         else if (apb_wr && paddr == byte_addr(`SSTE_IDX_BASE_A))
            base_a_r <= pwdata[7:0];
         else if (apb_wr && paddr == byte_addr(`SSTE_IDX_BASE_B))
            base_b_r <= pwdata[7:0];
      end
   end

   // Bad opcode sticky bit; a new bad opcode wins over a clear
   always_ff @(posedge clk)
   begin
      if (srst)
         badop_r <= 1'b0;
      else if (ce)
      begin
         if (finish && kind_r == K_BAD)
            badop_r <= 1'b1;
         else if (apb_wr && paddr == byte_addr(`SSTE_IDX_STATUS) && pwdata[`SSTE_STAT_BADOP])
            badop_r <= 1'b0;
      end
   end
   // APB answer: one wait state, read data and error registered
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready_r  <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !hit;
         if (psel && penable && !pready_r)
            prdata_r <= (hit && !pwrite) ? rd_val : 32'h0000_0000;
      end
   end
   assign issue_ready  = issue_ready_r;
   assign done         = done_r;
   assign wb_en        = wb_en_r;
   assign wb_data      = wb_data_r;
   assign flags        = flags_r;
   assign base_a       = base_a_r;
   assign base_b       = base_b_r;
   assign cpu_clk_halt = cpu_halt_r;
   assign sys_clk_halt = sys_halt_r;
   assign prdata       = prdata_r;
   assign pready       = pready_r;
   assign pslverr      = pslverr_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_take_short;
      take && op_cycles(opcode) == `SSTE_CYC_SHORT;
   endsequence
   sequence s_take_long;
      take && op_cycles(opcode) == `SSTE_CYC_LONG;
   endsequence
   a_sra_shift_data: assert property (done_r && kind_r == K_SRA |-> wb_en_r && wb_data_r == {opd_r[7], opd_r[7:1]}) // [RQ1]
      else $error("shift result wrong");
   a_sra_flag_set: assert property (done_r && kind_r == K_SRA |-> flags_r[`SSTE_FLAG_C] == opd_r[0] && // [RQ2]
      !flags_r[`SSTE_FLAG_V] && flags_r[`SSTE_FLAG_D] == $past(flags_r[`SSTE_FLAG_D]))
      else $error("shift flags wrong");
   a_short_cycle_count: assert property (s_take_short ##1 ce [*4] |=> done_r) // [RQ3]
      else $error("four cycle instruction late");
   a_long_cycle_count: assert property (s_take_long ##1 ce [*6] |=> done_r) // [RQ16]
      else $error("six cycle instruction late");
   a_srp_both_bases: assert property (ce && finish && kind_r == K_SRP && ops_r[1:0] == 2'b00 |=> // [RQ5]
      base_a_r == ({ops_r[7:4], 4'h0} | (base_a_r & 8'h07)) && base_a_r[3] == 1'b0 && base_b_r[3] == 1'b1)
      else $error("both base load wrong");
   a_srp_keep_flags: assert property (ce && finish && kind_r == K_SRP |=> $stable(flags_r)) // [RQ6]
      else $error("pointer load changed flags");
   a_stop_halt_clk: assert property (ce && finish && kind_r == K_STOP |=> cpu_clk_halt && sys_clk_halt) // [RQ8]
      else $error("stop did not halt clocks");
   a_stop_retain_state: assert property (state_r == ST_STOP |=> $stable(base_a_r) && $stable(base_b_r) && // [RQ9]
      $stable(flags_r))
      else $error("state lost in stop");
   a_stop_exit_cause: assert property (state_r == ST_STOP && !ext_int |=> state_r == ST_STOP) // [RQ10]
      else $error("stop left without wake event");
   a_sub_borrow_data: assert property (done_r && kind_r == K_SUB |-> wb_data_r == opd_r - ops_r && // [RQ13]
      flags_r[`SSTE_FLAG_C] == (ops_r > opd_r))
      else $error("subtract result or borrow wrong");
   a_sub_dec_half: assert property (done_r && kind_r == K_SUB |-> flags_r[`SSTE_FLAG_D] && // [RQ15]
      flags_r[`SSTE_FLAG_H] == (ops_r[3:0] > opd_r[3:0]))
      else $error("subtract D or H wrong");
   a_swap_nibbles: assert property (done_r && kind_r == K_SWAP |-> wb_data_r == {opd_r[3:0], opd_r[7:4]} && // [RQ17]
      flags_r[`SSTE_FLAG_S] == opd_r[3])
      else $error("swap wrong");
   a_tcm_no_write: assert property (done_r && kind_r == K_TCM |-> !wb_en_r && // [RQ19]
      flags_r[`SSTE_FLAG_Z] == ((~opd_r & ops_r) == 8'h00) && !flags_r[`SSTE_FLAG_V])
      else $error("masked test wrong");
endmodule : sste_execute

/* File: tb/sste_execute_bench.sv */
// Self-checking testbench for the shift, subtract and test execute block
`timescale 1ns/1ps
`include "sste_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module sste_execute_bench
   import sste_pkg::*;
;
   localparam logic [11:0] A_BASE_A = {2'b00, `SSTE_IDX_BASE_A, 2'b00};
   localparam logic [11:0] A_BASE_B = {2'b00, `SSTE_IDX_BASE_B, 2'b00};
   localparam logic [11:0] A_FLAGS  = {2'b00, `SSTE_IDX_FLAGS, 2'b00};
   localparam logic [11:0] A_STATUS = {2'b00, `SSTE_IDX_STATUS, 2'b00};

   // Stimulus
   logic        clk     = 1'b0;
   logic        srst    = 1'b1;
   logic        ce      = 1'b1;
   logic        issue   = 1'b0;
   logic [7:0]  opcode  = 8'h00;
   logic [7:0]  dst_val = 8'h00;
   logic [7:0]  src_val = 8'h00;
   logic        ext_int = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h00000000;
   // Observed
   logic        issue_ready;
   logic        done;
   logic        wb_en;
   logic [7:0]  wb_data;
   logic [7:0]  flags;
   logic [7:0]  base_a;
   logic [7:0]  base_b;
   logic        cpu_clk_halt;
   logic        sys_clk_halt;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   // Captured at completion; flag layout is C Z S V D H b1 b0
   logic [7:0]  r_wb;
   logic        r_we;
   logic [7:0]  r_fl;
   logic [7:0]  fexp;
   int          fail_count = 0;
   int          num_checks = 0;

   sste_execute dut_u
   (
      .clk          (clk),
      .srst         (srst),
      .ce           (ce),
      .issue        (issue),
      .opcode       (opcode),
      .dst_val      (dst_val),
      .src_val      (src_val),
      .issue_ready  (issue_ready),
      .done         (done),
      .wb_en        (wb_en),
      .wb_data      (wb_data),
      .flags        (flags),
      .base_a       (base_a),
      .base_b       (base_b),
      .ext_int      (ext_int),
      .cpu_clk_halt (cpu_clk_halt),
      .sys_clk_halt (sys_clk_halt),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr)
   );

   always #4 clk = ~clk;

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic hang;
      fail_count++;
      end_sim();
   endtask : hang

   // Request held from setup until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) hang();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h00000000, rd, err);
      `CHK(rd, exp)
      `CHK(err, exp_err)
   endtask : rd_chk

   // Issue one instruction and count edges from the taking edge to completion
   task automatic exec(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input int cyc);
      int n;
      @(posedge clk);
      issue   <= 1'b1;
      opcode  <= op;
      dst_val <= d;
      src_val <= s;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (issue_ready === 1'b1) break;
      end
      if (n == 20) hang();
      issue <= 1'b0;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (done === 1'b1) break;
      end
      if (n == 20) hang();
      `CHK(n, cyc)
      r_wb = wb_data;
      r_we = wb_en;
      r_fl = flags;
   endtask : exec

   function automatic logic [7:0] sub_fl(input logic [7:0] d, input logic [7:0] s, input logic [7:0] f);
      logic [7:0] r;
      r = d - s;
      return {s > d, r == 8'h00, r[7], (d[7] != s[7]) && (r[7] == s[7]), 1'b1, d[3:0] < s[3:0], f[1:0]};
   endfunction : sub_fl

   task automatic t_reset;
      rd_chk(A_BASE_A, {24'h0, `SSTE_RST_BASE_A}, 1'b0);
      rd_chk(A_BASE_B, {24'h0, `SSTE_RST_BASE_B}, 1'b0);
      rd_chk(A_FLAGS, {24'h0, `SSTE_RST_FLAGS}, 1'b0);
      rd_chk(12'h004, 32'h00000000, 1'b1);
      fexp = 8'h1F;
      wr(A_FLAGS, {24'h0, fexp});
      rd_chk(A_FLAGS, {24'h0, fexp}, 1'b0);
      wr(A_BASE_B, 32'h00000050);
      rd_chk(A_BASE_B, 32'h00000050, 1'b0);
      $display("reset and register test done");
   endtask : t_reset

   task automatic t_sra;
      logic [7:0] d [2] = '{8'h9A, 8'h01};
      for (int i = 0; i < 2; i++)
      begin
         exec(i == 0 ? `SSTE_OP_SRA_R : `SSTE_OP_SRA_IR, d[i], 8'h00, 4);
         `CHK(r_wb, {d[i][7], d[i][7:1]})
         `CHK(r_we, 1'b1)
         fexp = {d[i][0], d[i][7:1] == 7'h00 && !d[i][7], d[i][7], 1'b0, fexp[3:0]};
         `CHK(r_fl, fexp)
      end
      $display("shift test done");
   endtask : t_sra

   task automatic t_srp;
      // Source value, then expected first and second base
      logic [7:0] v [5][3] = '{'{8'h40, 8'h40, 8'h48}, '{8'h52, 8'h50, 8'h48},
                               '{8'h69, 8'h50, 8'h68}, '{8'h00, 8'h00, 8'h08}, '{8'h0B, 8'h00, 8'h08}};
      for (int i = 0; i < 5; i++)
      begin
         exec(`SSTE_OP_SRP, 8'h00, v[i][0], 4);
         `CHK(base_a, v[i][1])
         `CHK(base_b, v[i][2])
         `CHK(r_we, 1'b0)
         `CHK(r_fl, fexp)
      end
      rd_chk(A_BASE_A, 32'h00000000, 1'b0);
      rd_chk(A_BASE_B, 32'h00000008, 1'b0);
      $display("pointer load test done");
   endtask : t_srp

   task automatic t_sub;
      logic [7:0] v [5][2] = '{'{8'h12, 8'h03}, '{8'h80, 8'h01}, '{8'h03, 8'h05},
                               '{8'h21, 8'h21}, '{8'h7F, 8'hFF}};
      for (int i = 0; i < 5; i++)
      begin
         exec(`SSTE_OP_SUB_BASE + 8'(i), v[i][0], v[i][1], i == 0 ? 4 : 6);
         `CHK(r_wb, 8'(v[i][0] - v[i][1]))
         `CHK(r_we, 1'b1)
         fexp = sub_fl(v[i][0], v[i][1], fexp);
         `CHK(r_fl, fexp)
      end
      $display("subtract test done");
   endtask : t_sub

   task automatic t_swap;
      logic [7:0] d [2] = '{8'h3E, 8'h00};
      for (int i = 0; i < 2; i++)
      begin
         exec(i == 0 ? `SSTE_OP_SWAP_R : `SSTE_OP_SWAP_IR, d[i], 8'h00, 4);
         `CHK(r_wb, {d[i][3:0], d[i][7:4]})
         fexp = {fexp[7], d[i] == 8'h00, d[i][3], fexp[4:0]};
         `CHK(r_fl, fexp)
      end
      $display("swap test done");
   endtask : t_swap

   task automatic t_tcm;
      logic [7:0] v [5][2] = '{'{8'hC7, 8'h02}, '{8'h2B, 8'h34}, '{8'h00, 8'h80},
                               '{8'hFF, 8'hFF}, '{8'h0F, 8'hF0}};
      logic [7:0] r;
      for (int i = 0; i < 5; i++)
      begin
         exec(`SSTE_OP_TCM_BASE + 8'(i), v[i][0], v[i][1], i == 0 ? 4 : 6);
         r = ~v[i][0] & v[i][1];
         `CHK(r_we, 1'b0)
         fexp = {fexp[7], r == 8'h00, r[7], 1'b0, fexp[3:0]};
         `CHK(r_fl, fexp)
      end
      $display("masked test done");
   endtask : t_tcm

   task automatic t_stop;
      exec(`SSTE_OP_STOP, 8'h00, 8'h00, 4);
      `CHK({cpu_clk_halt, sys_clk_halt}, 2'b11)
      `CHK(r_fl, fexp)
      wr(A_BASE_A, 32'h000000AA);
      rd_chk(A_BASE_A, 32'h00000000, 1'b0);
      @(posedge clk);
      issue <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(done, 1'b0)
      `CHK(issue_ready, 1'b0)
      `CHK({flags, base_b}, {fexp, 8'h08})
      issue <= 1'b0;
      @(posedge clk);
      ext_int <= 1'b1;
      @(posedge clk);
      ext_int <= 1'b0;
      @(posedge clk);
      `CHK({cpu_clk_halt, sys_clk_halt}, 2'b00)
      exec(`SSTE_OP_STOP, 8'h00, 8'h00, 4);
      // Wake through reset; stabilisation wait is the outside party's job
      @(posedge clk);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      `CHK({cpu_clk_halt, sys_clk_halt}, 2'b00)
      $display("stop test done");
   endtask : t_stop

   task automatic t_badop;
      exec(8'h00, 8'h55, 8'h11, 4);
      `CHK(r_we, 1'b0)
      rd_chk(A_STATUS, 32'h00000004, 1'b0);
      wr(A_STATUS, 32'h00000004);
      rd_chk(A_STATUS, 32'h00000000, 1'b0);
      // Clock enable low freezes the block, so a pending issue is not taken
      @(posedge clk);
      ce      <= 1'b0;
      issue   <= 1'b1;
      opcode  <= `SSTE_OP_SWAP_R;
      dst_val <= 8'h12;
      repeat (8) @(posedge clk);
      `CHK({done, issue_ready, wb_data}, {1'b0, 1'b1, r_wb})
      issue   <= 1'b0;
      ce      <= 1'b1;
      $display("unknown opcode test done");
   endtask : t_badop

   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_sra();
      t_srp();
      t_sub();
      t_swap();
      t_tcm();
      t_stop();
      t_badop();
      end_sim();
   end
endmodule : sste_execute_bench
